/* File: verilog/bst_pkg.sv */
// Package: constants, states and carriers of the boundary-scan test access port
package bst_pkg;

    // ==========================================================
    // Register sizes, instruction codes, reset and capture values
    localparam int BST_IR_W = 4;
    localparam int BST_ID_W = 32;
    localparam logic [BST_IR_W-1:0] BST_IR_BYPASS = 4'hf;
    localparam logic [BST_IR_W-1:0] BST_IR_IDCODE = 4'h2;
    localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 4'h1;
    localparam logic [BST_ID_W-1:0] BST_IDCODE_DEFAULT = 32'h0000_0001;
    localparam logic BST_BYPASS_CAPTURE = 1'b0;

    // ==========================================================
    // Controller states
    typedef enum logic [3:0] {
        BST_TLR = 4'h0,
        BST_RTI = 4'h1,
        BST_SEL_DR = 4'h2,
        BST_CAP_DR = 4'h3,
        BST_SHF_DR = 4'h4,
        BST_EX1_DR = 4'h5,
        BST_PAU_DR = 4'h6,
        BST_EX2_DR = 4'h7,
        BST_UPD_DR = 4'h8,
        BST_SEL_IR = 4'h9,
        BST_CAP_IR = 4'ha,
        BST_SHF_IR = 4'hb,
        BST_EX1_IR = 4'hc,
        BST_PAU_IR = 4'hd,
        BST_EX2_IR = 4'he,
        BST_UPD_IR = 4'hf
    } bst_state_t;

    // ==========================================================
    // Serial output pin carrier
    typedef struct packed {
        logic data;
        logic oe_n;
    } bst_tdo_t;

endpackage : bst_pkg

/* File: verilog/bst_tap_port.sv */
// Boundary-scan test access port: controller, instruction, ID and bypass registers
// Behaviour
// - Test data in is shifted on rising test clock into IR, ID or bypass.
// - Test data out changes on falling test clock from the selected register.
// - Test data out is high impedance except in Shift-DR and Shift-IR.
// - Test reset pin resets the controller asynchronously, without test clock.
// - Five test clocks with mode select high reach the reset state.
// - No power-up reset; state undefined until pin or mode-select reset.
// - Functional outputs stay high impedance until the controller was reset.
// - Controller walks its state sequence following the mode select level.
// - Mode select is sampled on the rising test clock edge.
`timescale 1ns/1ps
`default_nettype none

module bst_tap_port
    import bst_pkg::*;
#(
    parameter logic [BST_ID_W-1:0] ID_CODE = BST_IDCODE_DEFAULT // Arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe_n,
    output logic o_func_out_en_n
);

    // ==========================================================
    // Instruction decode shared by the shift path and the output selection

    // Only the identification instruction reaches the long register; all else is bypass
    function automatic logic bst_id_selected(input logic [BST_IR_W-1:0] instr);
        return instr == BST_IR_IDCODE;
    endfunction : bst_id_selected

    // ==========================================================
    // Test clock domain: controller and scan registers

    // Controller state
    bst_state_t state;
    bst_state_t next_state;

    // Active instruction and its shift stage
    logic [BST_IR_W-1:0] ir;
    logic [BST_IR_W-1:0] next_ir;
    logic [BST_IR_W-1:0] ir_shift;
    logic [BST_IR_W-1:0] next_ir_shift;

    // Identification and bypass shift stages
    logic [BST_ID_W-1:0] id_shift;
    logic [BST_ID_W-1:0] next_id_shift;
    logic bypass;
    logic next_bypass;

    // Sticky reset-seen flag and the registered output pin pair
    logic tap_reset_seen;
    logic next_tap_reset_seen;
    bst_tdo_t tdo_q;
    bst_tdo_t next_tdo;

    // Next state follows mode select as sampled at the rising edge
    // From any state, five rising edges with mode select high end in reset
    always_comb begin
        next_state = state;
        unique case (state)
            BST_TLR: next_state = i_tms ? BST_TLR : BST_RTI;
            BST_RTI: next_state = i_tms ? BST_SEL_DR : BST_RTI;
            // Data register column
            BST_SEL_DR: next_state = i_tms ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: next_state = i_tms ? BST_EX1_DR : BST_SHF_DR;
            BST_SHF_DR: next_state = i_tms ? BST_EX1_DR : BST_SHF_DR;
            BST_EX1_DR: next_state = i_tms ? BST_UPD_DR : BST_PAU_DR;
            BST_PAU_DR: next_state = i_tms ? BST_EX2_DR : BST_PAU_DR;
            BST_EX2_DR: next_state = i_tms ? BST_UPD_DR : BST_SHF_DR;
            BST_UPD_DR: next_state = i_tms ? BST_SEL_DR : BST_RTI;
            // Instruction register column
            BST_SEL_IR: next_state = i_tms ? BST_TLR : BST_CAP_IR;
            BST_CAP_IR: next_state = i_tms ? BST_EX1_IR : BST_SHF_IR;
            BST_SHF_IR: next_state = i_tms ? BST_EX1_IR : BST_SHF_IR;
            BST_EX1_IR: next_state = i_tms ? BST_UPD_IR : BST_PAU_IR;
            BST_PAU_IR: next_state = i_tms ? BST_EX2_IR : BST_PAU_IR;
            BST_EX2_IR: next_state = i_tms ? BST_UPD_IR : BST_SHF_IR;
            BST_UPD_IR: next_state = i_tms ? BST_SEL_DR : BST_RTI;
        endcase
    end

    // Scan register next values; shift moves towards bit zero
    // Capture states load fixed patterns; update makes the shifted instruction live
    always_comb begin
        next_ir = ir;
        next_ir_shift = ir_shift;
        next_id_shift = id_shift;
        next_bypass = bypass;
        next_tap_reset_seen = tap_reset_seen;
        unique case (state)
            BST_TLR: begin
                next_ir = BST_IR_IDCODE; // ID register selected after reset
                next_tap_reset_seen = 1'b1;
            end
            BST_CAP_IR: next_ir_shift = BST_IR_CAPTURE;
            BST_SHF_IR: next_ir_shift = {i_tdi, ir_shift[BST_IR_W-1:1]};
            BST_UPD_IR: next_ir = ir_shift;
            BST_CAP_DR: begin
                next_id_shift = ID_CODE;
                next_bypass = BST_BYPASS_CAPTURE;
            end
            BST_SHF_DR: begin
                if (bst_id_selected(ir)) begin
                    next_id_shift = {i_tdi, id_shift[BST_ID_W-1:1]};
                end else begin
                    next_bypass = i_tdi;
                end
            end
            default: begin
                next_ir = ir;
            end
        endcase
    end

    // No power-up value: only the test reset pin or the mode-select walk defines state
    // Limitation: in silicon the flag may wake up set; where outputs must stay blocked
    // from power-up, tie the test reset to the master reset
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            state <= BST_TLR;
            ir <= BST_IR_IDCODE;
            tap_reset_seen <= 1'b1;
        end else begin
            state <= next_state;
            ir <= next_ir;
            tap_reset_seen <= next_tap_reset_seen;
        end
    end

    // Shift stages need no reset: they are always captured before use
    // Leaving them unreset keeps the long chain free of reset routing
    always_ff @(posedge i_tck) begin
        ir_shift <= next_ir_shift;
        id_shift <= next_id_shift;
        bypass <= next_bypass;
    end

    // Output selection; anything but an ID instruction reads the bypass bit
    always_comb begin
        next_tdo.data = 1'b0;
        next_tdo.oe_n = 1'b1;
        if (state == BST_SHF_IR) begin
            next_tdo.data = ir_shift[0];
            next_tdo.oe_n = 1'b0;
        end else if (state == BST_SHF_DR) begin
            next_tdo.data = bst_id_selected(ir) ? id_shift[0] : bypass;
            next_tdo.oe_n = 1'b0;
        end
    end

    // Falling edge keeps half a test clock of hold for the controller's sampling
    // Test reset idles the pin pair at once, even with the test clock stopped
    always_ff @(negedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            tdo_q <= '{data: 1'b0, oe_n: 1'b1};
        end else begin
            tdo_q <= next_tdo;
        end
    end

    // Carrier unpacked onto the two serial output pins
    assign o_tdo = tdo_q.data;
    assign o_tdo_oe_n = tdo_q.oe_n;

    // ==========================================================
    // System clock domain: release of functional outputs
    logic sync_meta;
    logic sync_seen;
    logic next_sync_meta;
    logic next_sync_seen;

    // The reset-seen level is sticky, so a plain two-stage synchroniser suffices
    // The second stage holds once a definite one arrives; an undefined flag from
    // an unreset controller never frees the outputs
    always_comb begin
        next_sync_meta = tap_reset_seen;
        next_sync_seen = sync_seen;
        if (sync_meta) begin
            next_sync_seen = 1'b1;
        end
    end

    // Both stages clear with the system reset, so outputs block during it
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync_meta <= 1'b0;
            sync_seen <= 1'b0;
        end else begin
            sync_meta <= next_sync_meta;
            sync_seen <= next_sync_seen;
        end
    end

    // Functional drivers stay off until the test port has been reset once
    assign o_func_out_en_n = ~sync_seen;

endmodule : bst_tap_port

`default_nettype wire

/* File: bench/bst_tap_monitor.sv */
// Checker of the test port pins
`timescale 1ns/1ps
`default_nettype none
module bst_tap_monitor (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire logic i_tms,
    input wire logic o_tdo,
    input wire logic o_tdo_oe_n,
    input wire logic o_func_out_en_n
);
    // ========
    // Pin pair is judged at the falling test clock, where it changes;
    // sampled there, it still shows the previous falling edge's value
    sequence s_five; i_tms [*5]; endsequence
    sequence s_quit; !o_tdo_oe_n && i_tms; endsequence
    property p_five; @(negedge i_tck) disable iff (!i_trst_n) s_five |-> o_tdo_oe_n; endproperty
    a_five: assert property (p_five) else $error("five");
    property p_enter; @(negedge i_tck) disable iff (!i_trst_n)
        $fell(o_tdo_oe_n) |-> !$past(i_tms); endproperty
    a_enter: assert property (p_enter) else $error("enter");
    property p_quit; @(negedge i_tck) disable iff (!i_trst_n) s_quit |=> o_tdo_oe_n; endproperty
    a_quit: assert property (p_quit) else $error("quit");
    property p_idle; @(negedge i_tck) disable iff (!i_trst_n) o_tdo_oe_n |-> !o_tdo; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    // System clock view: edge timing, async reset and output blocking
    property p_edge; @(posedge i_clk_sys) disable iff (i_reset)
        $changed({o_tdo, o_tdo_oe_n}) |-> !i_tck; endproperty
    a_edge: assert property (p_edge) else $error("edge");
    property p_trst; @(posedge i_clk_sys) disable iff (i_reset)
        !i_trst_n |-> o_tdo_oe_n && !o_tdo; endproperty
    a_trst: assert property (p_trst) else $error("trst");
    property p_rel; @(posedge i_clk_sys) disable iff (i_reset)
        $fell(i_reset) |-> o_func_out_en_n; endproperty
    a_rel: assert property (p_rel) else $error("rel");
    property p_free; @(posedge i_clk_sys) disable iff (i_reset)
        !i_trst_n |-> ##[1:4] !o_func_out_en_n; endproperty
    a_free: assert property (p_free) else $error("free");
endmodule : bst_tap_monitor
bind bst_tap_port bst_tap_monitor u_mon (.i_clk_sys, .i_reset, .i_tck, .i_trst_n, .i_tms,
    .o_tdo, .o_tdo_oe_n, .o_func_out_en_n);
`default_nettype wire

/* File: bench/bst_tester.sv */
// Model of the external scan controller
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi
);
    // ========
    // Clock stands low between frames; data lines rest at pull-up level
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // One 160 ns test clock; the pins stand across both edges
    task automatic step(input logic m, input logic d);
        o_tms = m;
        o_tdi = d;
        #79 o_tck = 1'b1;
        #80 o_tck = 1'b0;
        #1;
    endtask : step
endmodule : bst_tester
`default_nettype wire

/* File: bench/bst_tap_port_test.sv */
// Self-checking bench of the test port
`timescale 1ns/1ps
`default_nettype none
module bst_tap_port_test;
    import bst_pkg::*;
    logic clk = 1'b0, rst = 1'b1, trst_n = 1'b1;
    logic tck, tms, tdi, tdo, oe_n, fen_n;
    logic [2:0] exp_q[$];
    logic [31:0] rnd = 32'h832e;
    int errors = 0, compares = 0, cyc = 0;
    // ========
    // Design, controller model, clock
    initial forever #5 clk = ~clk;
    bst_tester ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi));
    bst_tap_port dut (.i_clk_sys(clk), .i_reset(rst), .i_tck(tck), .i_trst_n(trst_n),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe_n(oe_n), .o_func_out_en_n(fen_n));
    task automatic check(input string n, input logic [1:0] e, input logic [1:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : check
    task automatic end_sim;
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // Note the expected pin pair (bit 2: worth comparing), then clock once
    task automatic st(input logic m, input logic d, input logic [2:0] e);
        exp_q.push_back(e);
        ctl.step(m, d);
    endtask : st
    task automatic walk(input logic [3:0] m, input int n);
        for (int i = n - 1; i >= 0; i--) st(m[i], 1'b1, 3'h0);
    endtask : walk
    function automatic logic [31:0] xs;
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    // Identification read from reset or idle, back to idle
    task automatic id_read;
        walk(4'h2, 3);
        for (int i = 0; i < 32; i++) st(1'b0, 1'b1, {2'b10, BST_IDCODE_DEFAULT[i]});
        st(1'b1, 1'b1, 3'h6);
        walk(4'h2, 2);
    endtask : id_read
    // Each falling test clock gives one result, matched to the oldest note
    always @(negedge tck) begin
        #2;
        if (exp_q.size() > 0 && exp_q[0][2]) check("tdo_pair", exp_q[0][1:0], {oe_n, tdo});
        if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
    // A hung run is cut well past the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (20) @(posedge clk);
        #1 check("func_en_n", 2'b01, {1'b0, fen_n});
        // Test reset alone with the clock stopped: pins idle at once, outputs freed
        trst_n = 1'b0;
        #20 check("tdo_pair", 2'b10, {oe_n, tdo});
        @(posedge clk);
        #1 trst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 check("func_en_n", 2'b00, {1'b0, fen_n});
        id_read();
        // All-ones instruction through Pause-IR: capture pattern out, ones in
        walk(4'h6, 3);
        st(1'b0, 1'b1, 3'h5);
        for (int i = 0; i < 3; i++) st(1'b0, 1'b1, 3'h4);
        st(1'b1, 1'b1, 3'h6);
        walk(4'h3, 4);
        walk(4'h2, 2);
        st(1'b0, 1'b1, 3'h4);
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            st(1'b0, rnd[0], {2'b10, rnd[0]});
        end
        st(1'b1, 1'b1, 3'h6);
        walk(4'h1, 3);
        st(1'b0, 1'b1, 3'h5);
        // Five mode-select highs from Shift-DR must bring back the ID instruction
        for (int i = 0; i < 5; i++) st(1'b1, 1'b1, 3'h6);
        id_read();
        // Master reset with test reset tied to it, mid-shift with the clock stopped
        walk(4'h2, 3);
        st(1'b0, 1'b1, {2'b10, BST_IDCODE_DEFAULT[0]});
        @(posedge clk);
        #1 rst = 1'b1;
        trst_n = 1'b0;
        #20 check("tdo_pair", 2'b10, {oe_n, tdo});
        check("func_en_n", 2'b01, {1'b0, fen_n});
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        trst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 check("func_en_n", 2'b00, {1'b0, fen_n});
        id_read();
        end_sim();
    end
endmodule : bst_tap_port_test
`default_nettype wire
